// >>> design/cmc_pkg.sv
// constants, carriers and helpers shared by the core memory controller files
// assumes one 100 MHz core clock and a synchronous active-low reset
package cmc_pkg;

  // array geometry
  localparam int PLANES = 14;
  localparam int DATA_BITS = 13;
  localparam int WORD_BITS = 26;
  localparam int MODULES = 8;
  localparam int X_LINES = 128;
  localparam int Y_LINES = 64;
  localparam int PAR_POS = 13;
  localparam logic [3:0] RESID_SECTOR = 4'hF;
  localparam int RESID_ADDR_BIT = 8;

  // timing, in ns and in core clock cycles
  localparam int CLK_NS = 10;
  localparam int DRIVE_NS = 400;
  localparam int STROBE_NS = 250;
  localparam int RECOV_NS = 100;
  localparam int DRIVE_CYC = (DRIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHECK_CYC = 3;
  localparam int BIT_CYC = 4;
  localparam int CNT_W = 8;

  // reset values
  localparam logic [2:0] MOD_RST = 3'h0;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_CHECK = 3'b010,
    ST_STORE = 3'b011,
    ST_RECOV = 3'b100,
    ST_SEND = 3'b101
  } cmc_state_e;

  // access request from the computer side
  typedef struct packed {
    logic write;
    logic fetch;
    logic [3:0] sector;
    logic [8:0] addr;
    logic [WORD_BITS-1:0] wdata;
  } cmc_req_s;

  // timing pulses toward the array
  typedef struct packed {
    logic rd_drive;
    logic st_drive;
    logic strobe;
  } cmc_drv_s;

  // odd parity bit for one syllable
  function automatic logic odd_par(input logic [DATA_BITS-1:0] d);
    return ~(^d);
  endfunction

  // true when a stored syllable with parity has odd weight
  function automatic logic par_ok(input logic [PLANES-1:0] s);
    return ^s;
  endfunction

endpackage

// >>> design/cmc_addr_dec.sv
// address and module decoder for the core memory controller
// assumes its inputs are held stable by the sequencer during a cycle
`timescale 1ns/10ps
module cmc_addr_dec (
  // access
  input wire logic fetch,
  input wire logic [3:0] sector,
  input wire logic [8:0] addr,
  input wire logic syl,
  // module selection
  input wire logic duplex,
  input wire logic [2:0] fetch_mod,
  input wire logic [2:0] data_mod,
  // decoded lines
  output logic [cmc_pkg::X_LINES-1:0] x_onehot,
  output logic [cmc_pkg::Y_LINES-1:0] y_onehot,
  output logic [cmc_pkg::MODULES-1:0] mod_onehot
);

  // residual sector answers upper half of the address range
  wire resid = addr[cmc_pkg::RESID_ADDR_BIT];
  wire [3:0] eff_sector = resid ? cmc_pkg::RESID_SECTOR : sector;
  wire [11:0] word_idx = {eff_sector, addr[7:0]};
  // syllable picks the half of the 128 dimension
  wire [6:0] x_idx = {syl, word_idx[11:6]};
  wire [5:0] y_idx = word_idx[5:0];
  // instruction and operand modules chosen separately
  wire [2:0] mod_idx = fetch ? fetch_mod : data_mod;
  wire [2:0] pair_lo = {mod_idx[2:1], 1'b0};
  wire [cmc_pkg::MODULES-1:0] one_mod = 8'h01 << mod_idx;
  wire [cmc_pkg::MODULES-1:0] two_mod = 8'h03 << pair_lo;

  // exactly one line per dimension
  assign x_onehot = {{(cmc_pkg::X_LINES-1){1'b0}}, 1'b1} << x_idx;
  assign y_onehot = {{(cmc_pkg::Y_LINES-1){1'b0}}, 1'b1} << y_idx;
  assign mod_onehot = duplex ? two_mod : one_mod;

endmodule

// >>> design/cmc_ser.sv
// bit-serial sender of one 26-bit computer word, syllable 0 first, msb first
// assumes load comes while busy is low and bit_en is a one-cycle pulse
`timescale 1ns/10ps
module cmc_ser (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic bit_en,
  input wire logic load,
  input wire logic [cmc_pkg::WORD_BITS-1:0] word,
  // serial out
  output logic ser_bit,
  output logic ser_valid,
  output logic ser_last,
  output logic busy
);

  logic [cmc_pkg::WORD_BITS-1:0] sh_r;
  logic [4:0] left_r;

  // shift one bit per bit time
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sh_r <= '0;
      left_r <= 5'h00;
      ser_bit <= 1'b0;
      ser_valid <= 1'b0;
      ser_last <= 1'b0;
      busy <= 1'b0;
    end else if (load) begin
      sh_r <= word;
      left_r <= 5'(cmc_pkg::WORD_BITS);
      busy <= 1'b1;
      ser_valid <= 1'b0;
      ser_last <= 1'b0;
    end else if (bit_en && left_r != 5'h00) begin
      ser_bit <= sh_r[cmc_pkg::WORD_BITS-1];
      sh_r <= {sh_r[cmc_pkg::WORD_BITS-2:0], 1'b0};
      ser_valid <= 1'b1;
      ser_last <= (left_r == 5'h01);
      left_r <= left_r - 5'h01;
    end else if (bit_en) begin
      ser_valid <= 1'b0;
      ser_last <= 1'b0;
      busy <= 1'b0;
    end else begin
      ser_valid <= 1'b0; // valid stands one cycle per bit time
      ser_last <= 1'b0;
    end
  end

endmodule

// >>> design/cmc_ctrl.sv
// core memory controller: sequencing, buffer latches, parity and duplex select
// assumes sense inputs arrive asynchronously from the array sense amplifiers
//
// Overview of operation
// - one to eight modules, fourteen 128x64 planes
// - duplex pairs mirror contents; simplex modules independent
// - 128 dimension split into two syllable halves
// - sixteen sectors per half, last is residual
// - sector decodes 0-377, residual 400-777 octal
// - fetch and operand modules chosen by program
// - thirteen data planes plus one parity plane
// - two syllables joined, sent bit-serially
// - odd parity generated per syllable on write
// - parity checked on every read
// - read zeroes location, ones set latches
// - latches hold syllable until restored, word_r holds word until sent
// - store drives ones, zero latches inhibit
// - inhibit only during store cycles
// - exactly one X and one Y line
// - each plane has own sense and latch
// - clearing read suppresses sense strobe
// - duplex error restores from good buffer
`timescale 1ns/10ps
module cmc_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // access requests
  input wire logic req_valid,
  input wire cmc_pkg::cmc_req_s req,
  output logic req_ready,
  // module selection and mode
  input wire logic sel_load,
  input wire logic [2:0] sel_fetch_mod,
  input wire logic [2:0] sel_data_mod,
  input wire logic duplex,
  // error status
  input wire logic [1:0] err_clr,
  output logic par_err_a,
  output logic par_err_b,
  output logic both_fail,
  output logic feed_b,
  // serial read data
  output logic ser_bit,
  output logic ser_valid,
  output logic ser_last,
  // array drive
  output logic [cmc_pkg::X_LINES-1:0] x_line,
  output logic [cmc_pkg::Y_LINES-1:0] y_line,
  output logic [cmc_pkg::MODULES-1:0] mod_en,
  output cmc_pkg::cmc_drv_s drv,
  output logic [cmc_pkg::PLANES-1:0] inh_a,
  output logic [cmc_pkg::PLANES-1:0] inh_b,
  // array sense
  input wire logic [cmc_pkg::PLANES-1:0] sense_a,
  input wire logic [cmc_pkg::PLANES-1:0] sense_b
);

  cmc_pkg::cmc_state_e state_r;
  cmc_pkg::cmc_state_e state_nxt;
  cmc_pkg::cmc_req_s req_r;
  logic [cmc_pkg::CNT_W-1:0] cnt_r;
  logic syl_r;
  logic dup_r;
  logic strobed_r;
  logic [2:0] fetch_mod_r;
  logic [2:0] data_mod_r;
  logic [cmc_pkg::PLANES-1:0] sa_meta_r;
  logic [cmc_pkg::PLANES-1:0] sa_r;
  logic [cmc_pkg::PLANES-1:0] sb_meta_r;
  logic [cmc_pkg::PLANES-1:0] sb_r;
  logic [cmc_pkg::PLANES-1:0] buf_a_r;
  logic [cmc_pkg::PLANES-1:0] buf_b_r;
  logic [cmc_pkg::WORD_BITS-1:0] word_r;
  logic [1:0] bit_cnt_r;
  logic bit_en_r;
  logic ser_load_r;
  logic ser_busy;
  logic [cmc_pkg::X_LINES-1:0] x_dec;
  logic [cmc_pkg::Y_LINES-1:0] y_dec;
  logic [cmc_pkg::MODULES-1:0] mod_dec;
  cmc_pkg::cmc_req_s req_nx;
  logic syl_nx;
  logic dup_nx;

  // timer end points
  localparam logic [cmc_pkg::CNT_W-1:0] DRIVE_END = cmc_pkg::CNT_W'(cmc_pkg::DRIVE_CYC - 1);
  localparam logic [cmc_pkg::CNT_W-1:0] STROBE_AT = cmc_pkg::CNT_W'(cmc_pkg::STROBE_CYC);
  localparam logic [cmc_pkg::CNT_W-1:0] CHECK_END = cmc_pkg::CNT_W'(cmc_pkg::CHECK_CYC - 1);
  localparam logic [cmc_pkg::CNT_W-1:0] RECOV_END = cmc_pkg::CNT_W'(cmc_pkg::RECOV_CYC - 1);
  localparam logic [1:0] BIT_END = 2'(cmc_pkg::BIT_CYC - 1);

  // address and module decode
  cmc_addr_dec u_dec (
    .fetch(req_nx.fetch),
    .sector(req_nx.sector),
    .addr(req_nx.addr),
    .syl(syl_nx),
    .duplex(dup_nx),
    .fetch_mod(fetch_mod_r),
    .data_mod(data_mod_r),
    .x_onehot(x_dec),
    .y_onehot(y_dec),
    .mod_onehot(mod_dec)
  );

  // serial word sender
  cmc_ser u_ser (
    .core_clk(core_clk),
    .rstn(rstn),
    .bit_en(bit_en_r),
    .load(ser_load_r),
    .word(word_r),
    .ser_bit(ser_bit),
    .ser_valid(ser_valid),
    .ser_last(ser_last),
    .busy(ser_busy)
  );

  // timer and phase conditions
  wire drive_done = (cnt_r == DRIVE_END);
  wire check_done = (cnt_r == CHECK_END);
  wire recov_done = (cnt_r == RECOV_END);
  wire accept = (state_r == cmc_pkg::ST_IDLE) && req_valid;
  // decode what the next cycle holds, so lines settle as the drive starts
  assign req_nx = accept ? req : req_r;
  assign syl_nx = (state_r == cmc_pkg::ST_IDLE) ? 1'b0 :
                  (state_r == cmc_pkg::ST_RECOV && recov_done) ? 1'b1 : syl_r;
  assign dup_nx = accept ? duplex : dup_r;

  // write syllable with parity and parity checks of the latched buffers
  wire [cmc_pkg::DATA_BITS-1:0] wsyl = syl_r ? req_r.wdata[12:0] : req_r.wdata[25:13];
  wire [cmc_pkg::PLANES-1:0] wbuf = {cmc_pkg::odd_par(wsyl), wsyl};
  wire ok_a = cmc_pkg::par_ok(buf_a_r);
  wire ok_b = cmc_pkg::par_ok(buf_b_r) | ~dup_r;
  // duplex: selected bad and other good switches the feed
  wire feed_nxt = (feed_b && !ok_b && ok_a) ? 1'b0 :
                  (!feed_b && !ok_a && ok_b && dup_r) ? 1'b1 : feed_b;
  // good buffer drives the restore of both memories
  wire [cmc_pkg::PLANES-1:0] good_buf = (!ok_a && dup_r) ? buf_b_r : buf_a_r;
  wire [cmc_pkg::PLANES-1:0] feed_buf = (feed_nxt && dup_r) ? buf_b_r : buf_a_r;
  wire chk_end = (state_r == cmc_pkg::ST_CHECK) && check_done;
  wire rd_chk = chk_end && !req_r.write;
  wire set_err_a = rd_chk && !ok_a;
  wire set_err_b = rd_chk && !ok_b;
  wire set_both = rd_chk && dup_r && !ok_a && !ok_b;
  wire cap_en = strobed_r &&
                (state_r == cmc_pkg::ST_READ || (state_r == cmc_pkg::ST_CHECK && !check_done));
  // value the buffers take at check end, so inhibit is right from the first store cycle
  wire [cmc_pkg::PLANES-1:0] st_src = req_r.write ? wbuf : good_buf;
  wire [cmc_pkg::PLANES-1:0] st_buf_a = chk_end ? st_src : buf_a_r;
  wire [cmc_pkg::PLANES-1:0] st_buf_b = chk_end ? st_src : buf_b_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cmc_pkg::ST_IDLE: begin
        if (req_valid) begin
          state_nxt = cmc_pkg::ST_READ;
        end
      end
      cmc_pkg::ST_READ: begin
        if (drive_done) begin
          state_nxt = cmc_pkg::ST_CHECK;
        end
      end
      cmc_pkg::ST_CHECK: begin
        if (check_done) begin
          state_nxt = cmc_pkg::ST_STORE;
        end
      end
      cmc_pkg::ST_STORE: begin
        if (drive_done) begin
          state_nxt = cmc_pkg::ST_RECOV;
        end
      end
      cmc_pkg::ST_RECOV: begin
        if (recov_done && !syl_r) begin
          state_nxt = cmc_pkg::ST_READ;
        end else if (recov_done) begin
          state_nxt = req_r.write ? cmc_pkg::ST_IDLE : cmc_pkg::ST_SEND;
        end
      end
      cmc_pkg::ST_SEND: begin
        if (!ser_load_r && !ser_busy) begin
          state_nxt = cmc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = cmc_pkg::ST_IDLE;
      end
    endcase
  end

  // state, timer and syllable counter
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= cmc_pkg::ST_IDLE;
      cnt_r <= '0;
      syl_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
      if (state_r == cmc_pkg::ST_IDLE) begin
        syl_r <= 1'b0;
      end else if (state_r == cmc_pkg::ST_RECOV && recov_done) begin
        syl_r <= 1'b1;
      end
    end
  end

  // request capture, only while idle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      req_r <= '0;
      dup_r <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_nxt == cmc_pkg::ST_IDLE);
      if (accept) begin
        req_r <= req;
        dup_r <= duplex;
      end
    end
  end

  // program-set module selection
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fetch_mod_r <= cmc_pkg::MOD_RST;
      data_mod_r <= cmc_pkg::MOD_RST;
    end else if (sel_load) begin
      fetch_mod_r <= sel_fetch_mod;
      data_mod_r <= sel_data_mod;
    end
  end

  // two-flop synchronisers on the sense inputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sa_meta_r <= '0;
      sa_r <= '0;
      sb_meta_r <= '0;
      sb_r <= '0;
    end else begin
      sa_meta_r <= sense_a;
      sa_r <= sa_meta_r;
      sb_meta_r <= sense_b;
      sb_r <= sb_meta_r;
    end
  end

  // buffer latches: cleared at read start, set by sensed ones
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      buf_a_r <= '0;
      buf_b_r <= '0;
    end else if (state_r != cmc_pkg::ST_READ && state_nxt == cmc_pkg::ST_READ) begin
      buf_a_r <= '0;
      buf_b_r <= '0;
    end else if (cap_en) begin
      buf_a_r <= buf_a_r | sa_r;
      buf_b_r <= buf_b_r | (dup_r ? sb_r : '0);
    end else if (chk_end && req_r.write) begin
      buf_a_r <= wbuf;
      buf_b_r <= dup_r ? wbuf : '0;
    end else if (chk_end) begin
      buf_a_r <= good_buf;
      buf_b_r <= dup_r ? good_buf : '0;
    end
  end

  // strobe tracking and word assembly
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strobed_r <= 1'b0;
      word_r <= '0;
    end else begin
      if (state_r != cmc_pkg::ST_READ) begin
        strobed_r <= strobed_r && state_r == cmc_pkg::ST_CHECK;
      end else if (cnt_r == STROBE_AT && !req_r.write) begin
        strobed_r <= 1'b1;
      end
      if (rd_chk && !syl_r) begin
        word_r[25:13] <= feed_buf[12:0];
      end else if (rd_chk) begin
        word_r[12:0] <= feed_buf[12:0];
      end
    end
  end

  // parity error flags, a set beats a clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      par_err_a <= 1'b0;
      par_err_b <= 1'b0;
      both_fail <= 1'b0;
      feed_b <= 1'b0;
    end else begin
      par_err_a <= set_err_a | (par_err_a & ~err_clr[0]);
      par_err_b <= set_err_b | (par_err_b & ~err_clr[1]);
      both_fail <= set_both | (both_fail & ~(&err_clr));
      if (rd_chk) begin
        feed_b <= feed_nxt & dup_r;
      end
    end
  end

  // bit time enable and serial load
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bit_cnt_r <= 2'h0;
      bit_en_r <= 1'b0;
      ser_load_r <= 1'b0;
    end else begin
      bit_cnt_r <= (bit_cnt_r == BIT_END) ? 2'h0 : bit_cnt_r + 2'h1;
      bit_en_r <= (bit_cnt_r == BIT_END);
      ser_load_r <= (state_r != cmc_pkg::ST_SEND) && (state_nxt == cmc_pkg::ST_SEND);
    end
  end

  // drive lines, timing pulses and inhibit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      x_line <= {{(cmc_pkg::X_LINES-1){1'b0}}, 1'b1};
      y_line <= {{(cmc_pkg::Y_LINES-1){1'b0}}, 1'b1};
      mod_en <= '0;
      drv <= '0;
      inh_a <= '0;
      inh_b <= '0;
    end else begin
      x_line <= x_dec;
      y_line <= y_dec;
      mod_en <= (state_nxt == cmc_pkg::ST_IDLE) ? '0 : mod_dec;
      drv.rd_drive <= (state_nxt == cmc_pkg::ST_READ);
      drv.st_drive <= (state_nxt == cmc_pkg::ST_STORE);
      drv.strobe <= (state_r == cmc_pkg::ST_READ) && (cnt_r == STROBE_AT) && !req_r.write;
      inh_a <= (state_nxt == cmc_pkg::ST_STORE) ? ~st_buf_a : '0;
      inh_b <= (state_nxt == cmc_pkg::ST_STORE && dup_r) ? ~st_buf_b : '0;
    end
  end

endmodule

// >>> verif/cmc_ctrl_properties.sv
// timing checks on the controller ports
// assumes it is bound to cmc_ctrl with one clock domain
`timescale 1ns/10ps
module cmc_ctrl_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // observed ports
  input wire logic req_ready,
  input wire logic [1:0] err_clr,
  input wire logic par_err_a,
  input wire logic ser_valid,
  input wire logic [cmc_pkg::X_LINES-1:0] x_line,
  input wire logic [cmc_pkg::Y_LINES-1:0] y_line,
  input wire logic [cmc_pkg::MODULES-1:0] mod_en,
  input wire cmc_pkg::cmc_drv_s drv,
  input wire logic [cmc_pkg::PLANES-1:0] inh_a,
  input wire logic [cmc_pkg::PLANES-1:0] inh_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // address lines, inhibit, strobe, sequencing, serial spacing and error flag
  a_one_x_line: assert property ($onehot(x_line)) else $error("x line not one-hot");
  a_one_y_line: assert property ($onehot(y_line)) else $error("y line not one-hot");
  a_inh_store_only: assert property ((|inh_a || |inh_b) |-> drv.st_drive)
    else $error("inhibit outside store");
  a_strobe_in_read: assert property (drv.strobe |-> drv.rd_drive ##1 !drv.strobe)
    else $error("strobe outside read or too long");
  a_store_follows: assert property ($fell(drv.rd_drive) |-> ##[1:8] drv.st_drive)
    else $error("read not followed by store");
  a_drive_exclusive: assert property (!(drv.rd_drive && drv.st_drive))
    else $error("read and store drive together");
  a_addr_held: assert property ((drv.rd_drive || drv.st_drive) &&
    $past(drv.rd_drive || drv.st_drive) |-> $stable(x_line) && $stable(mod_en))
    else $error("address moved during drive");
  a_idle_quiet: assert property (req_ready |-> mod_en == 8'h00 && !drv.rd_drive)
    else $error("module enabled while idle");
  a_pair_even_odd: assert property (drv.rd_drive |-> $countones(mod_en) == 1 ||
    ($countones(mod_en) == 2 && (mod_en & (mod_en >> 1) & 8'h55) != 8'h00))
    else $error("bad module enable pattern");
  a_ser_spacing: assert property (ser_valid |=> !ser_valid) else $error("serial bit too long");
  a_err_sticky: assert property (par_err_a && !err_clr[0] |=> par_err_a)
    else $error("error flag dropped");
endmodule

// >>> verif/cmc_array_model.sv
// behavioural core array: modules, planes, sense and inhibit
// assumes drive levels and one-hot lines from the controller
`timescale 1ns/10ps
module cmc_array_model (
  // clock
  input wire logic core_clk,
  // drive side
  input wire logic [127:0] x_line,
  input wire logic [63:0] y_line,
  input wire logic [7:0] mod_en,
  input wire cmc_pkg::cmc_drv_s drv,
  input wire logic [13:0] inh_a,
  input wire logic [13:0] inh_b,
  // fault injection on memory a
  input wire logic flip_a,
  // sense side
  output logic [13:0] sense_a,
  output logic [13:0] sense_b
);
  bit [13:0] mem [0:65535];
  logic rd_q = 1'b0;
  int ka, kb;
  logic two;
  function automatic int pos(input logic [127:0] v, input bit hi);
    int r;
    bit f;
    r = 0;
    f = 0;
    for (int i = 0; i < 128; i++) if (v[i] && (hi || !f)) begin
      r = i;
      f = 1;
    end
    return r;
  endfunction
  // location keys, a is the low module, b the high one of a pair
  always_comb begin
    two = $countones(mod_en) == 2;
    ka = pos(mod_en, 0) * 8192 + pos(x_line, 0) * 64 + pos(y_line, 0);
    kb = pos(mod_en, 1) * 8192 + pos(x_line, 0) * 64 + pos(y_line, 0);
    sense_a = drv.rd_drive ? (mem[ka] ^ {13'h0, flip_a}) : 14'h0;
    sense_b = (drv.rd_drive && two) ? mem[kb] : 14'h0;
  end
  // read clears the location, store sets all bits not inhibited
  always @(posedge core_clk) begin
    rd_q <= drv.rd_drive;
    if (rd_q && !drv.rd_drive) begin
      mem[ka] <= 14'h0;
      if (two) mem[kb] <= 14'h0;
    end
    if (drv.st_drive) begin
      mem[ka] <= ~inh_a;
      if (two) mem[kb] <= ~inh_b;
    end
  end
endmodule

// >>> verif/core_memory_controller_tb_top.sv
// self-checking bench for the core memory controller
// assumes the array model stands behind the drive and sense ports
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module core_memory_controller_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic sel_load = 1'b0;
  logic duplex = 1'b0;
  logic flip_a = 1'b0;
  cmc_pkg::cmc_req_s req = '0;
  logic [2:0] sel_fetch_mod = 3'h0;
  logic [2:0] sel_data_mod = 3'h0;
  logic [1:0] err_clr = 2'h0;
  logic req_ready, par_err_a, par_err_b, both_fail, feed_b, ser_bit, ser_valid, ser_last;
  logic [127:0] x_line;
  logic [63:0] y_line;
  logic [7:0] mod_en;
  cmc_pkg::cmc_drv_s drv;
  logic [13:0] inh_a, inh_b, sense_a, sense_b;
  logic [25:0] rd;
  int failures = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  cmc_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .sel_load(sel_load), .sel_fetch_mod(sel_fetch_mod),
    .sel_data_mod(sel_data_mod), .duplex(duplex), .err_clr(err_clr), .par_err_a(par_err_a),
    .par_err_b(par_err_b), .both_fail(both_fail), .feed_b(feed_b), .ser_bit(ser_bit),
    .ser_valid(ser_valid), .ser_last(ser_last), .x_line(x_line), .y_line(y_line),
    .mod_en(mod_en), .drv(drv), .inh_a(inh_a), .inh_b(inh_b), .sense_a(sense_a),
    .sense_b(sense_b));
  cmc_array_model i_arr (.core_clk(core_clk), .x_line(x_line), .y_line(y_line),
    .mod_en(mod_en), .drv(drv), .inh_a(inh_a), .inh_b(inh_b), .flip_a(flip_a),
    .sense_a(sense_a), .sense_b(sense_b));
  // verdict and end of run
  task conclude;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access; a read collects the serial word into rd
  task access(input logic wr, input logic fe, input logic [3:0] sec, input logic [8:0] ad,
              input logic [25:0] wd);
    int i;
    int n;
    i = 0;
    n = 0;
    @(posedge core_clk);
    while (!req_ready) begin
      @(posedge core_clk);
      i++;
      if (i > 2000) begin failures++; conclude(); end
    end
    req_valid <= 1'b1;
    req <= '{wr, fe, sec, ad, wd};
    @(posedge core_clk);
    req_valid <= 1'b0;
    rd = 26'h0;
    while (!wr && n < 26) begin
      @(posedge core_clk);
      i++;
      if (i > 4000) begin failures++; conclude(); end
      if (ser_valid) begin
        rd = {rd[24:0], ser_bit};
        n++;
        `CHK(ser_last, n == 26)
      end
    end
  endtask
  task sel(input logic [2:0] f, input logic [2:0] d);
    sel_load <= 1'b1;
    sel_fetch_mod <= f;
    sel_data_mod <= d;
    @(posedge core_clk);
    sel_load <= 1'b0;
  endtask
  // reset values
  task t_reset;
    #1;
    `CHK(req_ready, 1'b1)
    `CHK({par_err_a, par_err_b, both_fail, mod_en}, 11'h000)
    `CHK({x_line[0], y_line[0]}, 2'b11)
  endtask
  // sector, residual and all-zero words read back; the sector word survives a second destructive read
  task t_simplex;
    access(1, 0, 4'h3, 9'h0FF, 26'h2ABCDEF);
    access(1, 0, 4'hF, 9'h1FF, 26'h1543210);
    access(1, 0, 4'h0, 9'h000, 26'h0000000);
    access(0, 0, 4'h3, 9'h0FF, 26'h0);
    `CHK(rd, 26'h2ABCDEF)
    access(0, 0, 4'hF, 9'h1FF, 26'h0);
    `CHK(rd, 26'h1543210)
    access(0, 0, 4'h0, 9'h000, 26'h0);
    `CHK(rd, 26'h0000000)
    access(0, 0, 4'h3, 9'h0FF, 26'h0);
    `CHK(rd, 26'h2ABCDEF)
    `CHK(par_err_a, 1'b0)
  endtask
  // fetch and operand modules differ
  task t_modsel;
    sel(3'h5, 3'h6);
    access(1, 0, 4'h3, 9'h0FF, 26'h0F0F0F0);
    access(1, 1, 4'h3, 9'h0FF, 26'h3030303);
    access(0, 0, 4'h3, 9'h0FF, 26'h0);
    `CHK(rd, 26'h0F0F0F0)
    access(0, 1, 4'h3, 9'h0FF, 26'h0);
    `CHK(rd, 26'h3030303)
  endtask
  // duplex read error on a is masked, flagged and repaired
  task t_duplex;
    sel(3'h2, 3'h2);
    duplex <= 1'b1;
    access(1, 0, 4'h7, 9'h042, 26'h1234567);
    flip_a <= 1'b1;
    access(0, 0, 4'h7, 9'h042, 26'h0);
    `CHK(rd, 26'h1234567)
    `CHK({par_err_a, par_err_b, both_fail, feed_b}, 4'b1001)
    flip_a <= 1'b0;
    err_clr <= 2'h1;
    @(posedge core_clk);
    err_clr <= 2'h0;
    @(posedge core_clk);
    `CHK(par_err_a, 1'b0)
    access(0, 0, 4'h7, 9'h042, 26'h0);
    `CHK(rd, 26'h1234567)
    `CHK(par_err_a, 1'b0)
    duplex <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_simplex();
    t_modsel();
    t_duplex();
    conclude();
  end
endmodule
bind cmc_ctrl cmc_ctrl_properties i_props (.core_clk(core_clk), .rstn(rstn),
  .req_ready(req_ready), .err_clr(err_clr), .par_err_a(par_err_a), .ser_valid(ser_valid),
  .x_line(x_line), .y_line(y_line), .mod_en(mod_en), .drv(drv), .inh_a(inh_a),
  .inh_b(inh_b));
